// file: hdl/pcc_config_header.sv
`timescale 1ns/100ps
// Configuration header slice: command register plus read-only ids.
// Addresses are dword aligned byte addresses; be selects lanes.
module pcc_config_header (
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire pcc_pkg::pcc_cfg_req_t cfg_req,
  output logic [31:0]               cfg_rdata,
  input  wire logic                 in_d0,
  input  wire logic                 rom_decode_en,
  input  wire logic                 irq_pending,
  input  wire logic                 system_error_req,
  input  wire logic                 parity_error_seen,
  output logic                      io_decode_en,
  output logic                      mem_decode_en,
  output logic                      initiator_en,
  output logic                      write_invalidate_en,
  output logic                      special_cycle_monitor,
  output logic                      palette_snoop,
  output logic                      back_to_back_en,
  output logic                      addr_data_stepping,
  output logic                      parity_react,
  output logic                      system_error_out_n,
  output logic                      irq_out_n,
  output logic                      non_config_en
);
  pcc_pkg::pcc_state_t st;
  pcc_pkg::pcc_state_t next_st;
  logic [15:0]         cmd_view;

  // Apply a byte-lane write to the writable command bits
  function automatic logic [15:0] cmd_write(input logic [15:0] cur,
                                            input logic [15:0] wd,
                                            input logic [1:0]  be);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & pcc_pkg::CMD_WR_MASK;
    cmd_write = (cur & ~lane) | (wd & lane);
  endfunction : cmd_write

  // Read-only bits are forced from constants, reserved bits stay zero
  always_comb begin
    cmd_view = st.pci_command & pcc_pkg::CMD_WR_MASK;
    cmd_view[pcc_pkg::BIT_SPECIAL] = 1'b0;
    cmd_view[pcc_pkg::BIT_PAL] = 1'b0;
    cmd_view[pcc_pkg::BIT_STEP] = pcc_pkg::STEPPING_VALUE;
    cmd_view[pcc_pkg::BIT_B2B] = 1'b0;
  end

  // Next state: command writes and registered read data
  always_comb begin
    next_st = st;
    next_st.rdata = 32'h00000000;
    if (cfg_req.wr && cfg_req.addr == pcc_pkg::CMD_OFS) begin
      next_st.pci_command = cmd_write(st.pci_command,
                                      cfg_req.wdata[15:0],
                                      cfg_req.be[1:0]);
    end
    if (cfg_req.rd) begin
      unique case (cfg_req.addr)
        pcc_pkg::CMD_OFS:
          next_st.rdata = {16'h0000, cmd_view};
        8'h08:
          // Class code occupies the upper three bytes of this dword
          next_st.rdata = {pcc_pkg::CLASS_VALUE, 8'h00};
        pcc_pkg::CAP_PTR_OFS:
          next_st.rdata = {24'h000000, pcc_pkg::CHAIN_START};
        pcc_pkg::CAP_ID_OFS:
          next_st.rdata = {24'h000000, pcc_pkg::CAP_TYPE_VALUE};
        default:
          next_st.rdata = 32'h00000000;
      endcase
      // Bytewise access: disabled lanes read zero
      next_st.rdata = next_st.rdata & {{8{cfg_req.be[3]}},
        {8{cfg_req.be[2]}}, {8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};
    end
  end

  // State register, cleared to the documented reset value
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st.pci_command <= pcc_pkg::CMD_RESET;
      st.rdata       <= 32'h00000000;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rdata = st.rdata;

  // Permissions: an all-zero command leaves only config cycles live
  assign non_config_en = |cmd_view;
  assign io_decode_en = cmd_view[pcc_pkg::BIT_IO] & in_d0;
  assign mem_decode_en = cmd_view[pcc_pkg::BIT_MEM] & rom_decode_en
                         & in_d0;
  assign initiator_en = cmd_view[pcc_pkg::BIT_MASTER] & in_d0;
  assign write_invalidate_en = cmd_view[pcc_pkg::BIT_MWI];
  assign special_cycle_monitor = cmd_view[pcc_pkg::BIT_SPECIAL];
  assign palette_snoop = cmd_view[pcc_pkg::BIT_PAL];
  assign back_to_back_en = cmd_view[pcc_pkg::BIT_B2B];
  assign addr_data_stepping = cmd_view[pcc_pkg::BIT_STEP];
  assign parity_react = cmd_view[pcc_pkg::BIT_PARITY]
                        & parity_error_seen;
  // Error line is low-active; disabled means a constant inactive level
  assign system_error_out_n = ~(cmd_view[pcc_pkg::BIT_SERR]
                                & system_error_req);
  // Blocking never touches irq_pending, which lives elsewhere
  assign irq_out_n = ~(irq_pending
                       & ~cmd_view[pcc_pkg::BIT_IRQ_BLK]);

  chk_reset_cmd_zero: assert property (@(posedge clock)
    $rose(nrst) |-> cfg_rdata == 32'h0 && !non_config_en)
    else $error("command not zero after reset");
  chk_io_needs_d0: assert property (@(posedge clock) disable iff (!nrst)
    io_decode_en |-> in_d0 && st.pci_command[0])
    else $error("io decode without permission");
  chk_rom_gate: assert property (@(posedge clock) disable iff (!nrst)
    mem_decode_en |-> rom_decode_en && in_d0 && st.pci_command[1])
    else $error("rom decode without permission");
  chk_master_gate: assert property (@(posedge clock) disable iff (!nrst)
    initiator_en |-> in_d0 && st.pci_command[2])
    else $error("mastering without permission");
  chk_cap_ptr: assert property (@(posedge clock) disable iff (!nrst)
    cfg_req.rd && cfg_req.addr == 8'h34 && cfg_req.be[0]
    |=> cfg_rdata[7:0] == 8'h50)
    else $error("capability pointer wrong");
  chk_class_read: assert property (@(posedge clock) disable iff (!nrst)
    cfg_req.rd && cfg_req.addr == 8'h08 && cfg_req.be == 4'hf
    |=> cfg_rdata == 32'h02000000)
    else $error("class code wrong");
  chk_reserved_zero: assert property (@(posedge clock) disable iff (!nrst)
    cfg_req.rd && cfg_req.addr == 8'h04 |=> cfg_rdata[15:11] == 5'h0
    && cfg_rdata[9] == 1'b0 && cfg_rdata[5] == 1'b0 && cfg_rdata[3] == 1'b0)
    else $error("read-only command bits moved");
  chk_serr_quiet: assert property (@(posedge clock) disable iff (!nrst)
    !st.pci_command[8] |-> system_error_out_n)
    else $error("system error while disabled");
  chk_irq_block: assert property (@(posedge clock) disable iff (!nrst)
    st.pci_command[10] |-> irq_out_n)
    else $error("interrupt while blocked");
  chk_irq_assert: assert property (@(posedge clock) disable iff (!nrst)
    irq_pending && !st.pci_command[10] |-> !irq_out_n)
    else $error("pending interrupt not driven");
  chk_mwi_write: assert property (@(posedge clock) disable iff (!nrst)
    cfg_req.wr && cfg_req.addr == 8'h04 && cfg_req.be[0]
    |=> write_invalidate_en == $past(cfg_req.wdata[4]))
    else $error("write invalidate enable not stored");

  // Hardwired command bits: software can never turn these features on

  // Special cycles are never monitored by this function
  chk_special_zero: assert property (@(posedge clock) disable iff (!nrst)
    !special_cycle_monitor)
    else $error("special cycle monitor set");

  // Palette writes are decoded like any other access
  chk_palette_zero: assert property (@(posedge clock) disable iff (!nrst)
    !palette_snoop)
    else $error("palette snoop set");

  // Stepping follows the fixed behaviour of the bus interface
  chk_step_fixed: assert property (@(posedge clock) disable iff (!nrst)
    addr_data_stepping == pcc_pkg::STEPPING_VALUE)
    else $error("stepping control moved");

  // Fast back-to-back stays off, so only same-agent bursts happen
  chk_b2b_zero: assert property (@(posedge clock) disable iff (!nrst)
    !back_to_back_en)
    else $error("back to back enable set");

  // Reserved bits must never be stored, not only masked on read
  chk_reserved_store: assert property (@(posedge clock) disable iff (!nrst)
    (st.pci_command & ~pcc_pkg::CMD_WR_MASK) == 16'h0000)
    else $error("reserved command bits stored");

  // Gating of the permission outputs, both directions

  // Parity reaction only when enabled and an error is seen
  chk_parity_gate: assert property (@(posedge clock) disable iff (!nrst)
    parity_react |-> st.pci_command[6] && parity_error_seen)
    else $error("parity reaction while ignored");

  // An enabled parity error must reach the reaction output
  chk_parity_pass: assert property (@(posedge clock) disable iff (!nrst)
    st.pci_command[6] && parity_error_seen |-> parity_react)
    else $error("parity error not reacted to");

  // An enabled system error request must drive the line
  chk_serr_pass: assert property (@(posedge clock) disable iff (!nrst)
    st.pci_command[8] && system_error_req |-> !system_error_out_n)
    else $error("system error not driven");

  // No pending status means the interrupt line stays released
  chk_irq_idle: assert property (@(posedge clock) disable iff (!nrst)
    !irq_pending |-> irq_out_n)
    else $error("interrupt without pending status");

  // Write invalidate permission mirrors its command bit exactly
  chk_mwi_gate: assert property (@(posedge clock) disable iff (!nrst)
    write_invalidate_en == st.pci_command[4])
    else $error("write invalidate gate wrong");

  // An all-zero command disconnects everything but config cycles
  chk_nonconfig_off: assert property (@(posedge clock) disable iff (!nrst)
    st.pci_command == 16'h0000 |-> !non_config_en && !io_decode_en
    && !mem_decode_en && !initiator_en)
    else $error("live decode with zero command");

  // A granted I/O permission must actually be given
  chk_io_grant: assert property (@(posedge clock) disable iff (!nrst)
    st.pci_command[0] && in_d0 |-> io_decode_en)
    else $error("io decode withheld");

  // ROM decode opens once all three conditions meet
  chk_rom_grant: assert property (@(posedge clock) disable iff (!nrst)
    st.pci_command[1] && rom_decode_en && in_d0 |-> mem_decode_en)
    else $error("rom decode withheld");

  // Mastering opens with the bit set in D0
  chk_master_grant: assert property (@(posedge clock) disable iff (!nrst)
    st.pci_command[2] && in_d0 |-> initiator_en)
    else $error("mastering withheld");

  // D0 loss must shut every D0-qualified permission at once
  chk_d0_shut: assert property (@(posedge clock) disable iff (!nrst)
    !in_d0 |-> !io_decode_en && !mem_decode_en && !initiator_en)
    else $error("permission outside D0");

  // Read path: registered data, lanes and read-only identifiers

  // Capability type byte reads its fixed code
  chk_cap_id_read: assert property (@(posedge clock) disable iff (!nrst)
    cfg_req.rd && cfg_req.addr == pcc_pkg::CAP_ID_OFS && cfg_req.be[0]
    |=> cfg_rdata[7:0] == pcc_pkg::CAP_TYPE_VALUE)
    else $error("capability type wrong");

  // Read data stands one cycle only, so stale data cannot leak
  chk_rdata_idle: assert property (@(posedge clock) disable iff (!nrst)
    !cfg_req.rd |=> cfg_rdata == 32'h00000000)
    else $error("read data without a read");

  // Disabled byte lanes read zero
  chk_lane_mask: assert property (@(posedge clock) disable iff (!nrst)
    cfg_req.rd && !cfg_req.be[0] |=> cfg_rdata[7:0] == 8'h00)
    else $error("disabled lane returned data");

  // Class code low byte, offset 9, reads zero
  chk_class_low: assert property (@(posedge clock) disable iff (!nrst)
    cfg_req.rd && cfg_req.addr == 8'h08 && cfg_req.be[1]
    |=> cfg_rdata[15:8] == 8'h00)
    else $error("class code low byte wrong");

  // Write path: address and lane qualification

  // Writes elsewhere never touch the command register
  chk_wr_other: assert property (@(posedge clock) disable iff (!nrst)
    cfg_req.wr && cfg_req.addr != pcc_pkg::CMD_OFS
    |=> st.pci_command == $past(st.pci_command))
    else $error("foreign write changed command");

  // A closed low lane keeps the low command byte
  chk_lane_guard: assert property (@(posedge clock) disable iff (!nrst)
    cfg_req.wr && cfg_req.addr == pcc_pkg::CMD_OFS && !cfg_req.be[0]
    |=> st.pci_command[7:0] == $past(st.pci_command[7:0]))
    else $error("closed lane written");

  // Interrupt block bit takes the written value
  chk_blk_write: assert property (@(posedge clock) disable iff (!nrst)
    cfg_req.wr && cfg_req.addr == pcc_pkg::CMD_OFS && cfg_req.be[1]
    |=> st.pci_command[10] == $past(cfg_req.wdata[10]))
    else $error("interrupt block not stored");

  // System error enable takes the written value
  chk_serr_write: assert property (@(posedge clock) disable iff (!nrst)
    cfg_req.wr && cfg_req.addr == pcc_pkg::CMD_OFS && cfg_req.be[1]
    |=> st.pci_command[8] == $past(cfg_req.wdata[8]))
    else $error("system error enable not stored");

  // I/O enable takes the written value
  chk_io_write: assert property (@(posedge clock) disable iff (!nrst)
    cfg_req.wr && cfg_req.addr == pcc_pkg::CMD_OFS && cfg_req.be[0]
    |=> st.pci_command[0] == $past(cfg_req.wdata[0]))
    else $error("io enable not stored");

  // Parity enable takes the written value
  chk_par_write: assert property (@(posedge clock) disable iff (!nrst)
    cfg_req.wr && cfg_req.addr == pcc_pkg::CMD_OFS && cfg_req.be[0]
    |=> st.pci_command[6] == $past(cfg_req.wdata[6]))
    else $error("parity enable not stored");
endmodule : pcc_config_header

// file: hdl/pcc_pkg.sv
// Behaviour
// - Capability chain start byte always reads 0x50.
// - Class code at 0x09 reads 0x020000, byte accessed.
// - Command at 0x04 resets to zero; then only config cycles work.
// - Bit 0 allows I/O decode only in D0.
// - Bit 1 with ROM decode enable allows ROM decode in D0.
// - Bit 2 allows bus mastering only in D0.
// - Bit 3 read-only zero; special cycles ignored.
// - Bit 4 permits memory write and invalidate.
// - Bit 5 read-only zero; palette writes treated normally.
// - Bit 6 enables parity error reaction, else ignored.
// - Bit 7 read-only, hardwired to fixed stepping behaviour.
// - Bit 8 gates system error; clear keeps the low-active line high.
// - Bit 9 read-only zero; back-to-back only to same agent.
// - Bit 10 set blocks the interrupt output.
// - Bits 15 to 11 reserved, read zero, writes ignored.
// - Capability id byte at 0x50 (lane 0) is a read-only type code.
// - Interrupt asserts only when pending and not blocked.
package pcc_pkg;
  localparam logic [7:0]  CMD_OFS        = 8'h04;
  localparam logic [7:0]  CLASS_OFS      = 8'h09;
  localparam logic [7:0]  CLASS_OFS_MID  = 8'h0a;
  localparam logic [7:0]  CLASS_OFS_HI   = 8'h0b;
  localparam logic [7:0]  CAP_PTR_OFS    = 8'h34;
  localparam logic [7:0]  CAP_ID_OFS     = 8'h50;
  localparam logic [15:0] CMD_RESET      = 16'h0000;
  localparam logic [15:0] CMD_WR_MASK    = 16'h0557;
  localparam logic [23:0] CLASS_VALUE    = 24'h020000;
  localparam logic [7:0]  CHAIN_START    = 8'h50;
  localparam logic [7:0]  CAP_TYPE_VALUE = 8'h01;
  localparam logic        STEPPING_VALUE = 1'b0;
  localparam int          BIT_IO      = 0;
  localparam int          BIT_MEM     = 1;
  localparam int          BIT_MASTER  = 2;
  localparam int          BIT_SPECIAL = 3;
  localparam int          BIT_MWI     = 4;
  localparam int          BIT_PAL     = 5;
  localparam int          BIT_PARITY  = 6;
  localparam int          BIT_STEP    = 7;
  localparam int          BIT_SERR    = 8;
  localparam int          BIT_B2B     = 9;
  localparam int          BIT_IRQ_BLK = 10;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcc_cfg_req_t;

  typedef struct packed {
    logic [15:0] pci_command;
    logic [31:0] rdata;
  } pcc_state_t;
endpackage : pcc_pkg

// file: sim/pcc_host_model.sv
`timescale 1ns/100ps
// Host side of configuration cycles; drives just after the rising edge
module pcc_host_model (
  input  wire logic             clock,
  output pcc_pkg::pcc_cfg_req_t cfg_req,
  input  wire logic [31:0]      cfg_rdata
);
  initial cfg_req = '0;
  // Idle bus shows inverted leftovers so stale values cannot pass
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
                           input logic [31:0] d);
    @(posedge clock) #1;
    cfg_req = '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: d};
    @(posedge clock) #1;
    cfg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: 4'h0, wdata: ~d};
  endtask : cfg_write
  // Read data stands one cycle after the taking edge
  task automatic cfg_read(input logic [7:0] a, input logic [3:0] be,
                          output logic [31:0] q);
    @(posedge clock) #1;
    cfg_req = '{rd: 1'b1, wr: 1'b0, addr: a, be: be, wdata: 32'h0};
    @(posedge clock) #1;
    q = cfg_rdata;
    cfg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: 4'h0, wdata: 32'h0};
  endtask : cfg_read
endmodule : pcc_host_model

// file: sim/pcc_config_header_tb_top.sv
`timescale 1ns/100ps
module pcc_config_header_tb_top;
  logic clock = 0, nrst = 0, d0 = 0, rom = 0, pend = 0, serr = 0, par = 0;
  logic io, mem, init, mwi, scm, pal, b2b, step, parr, serr_n, irq_n, nc;
  pcc_pkg::pcc_cfg_req_t req;
  logic [31:0]           rdata;
  logic [31:0]           q;
  int                    error_cnt = 0;
  int                    cmp_count = 0;
  // Inputs {d0,rom,pend,serr,par}; outputs {io,mem,init,mwi,par,serr,irq,nc}
  typedef struct packed {
    logic [15:0] cmd;
    logic [4:0]  ins;
    logic [7:0]  exp;
  } pcc_row_t;
  pcc_row_t rows [6] = '{
    '{16'h0557, 5'b11111, 8'b11111011}, '{16'h0557, 5'b01111, 8'b00011011},
    '{16'h0002, 5'b10110, 8'b00000101}, '{16'h0000, 5'b11111, 8'b00000100},
    '{16'h0001, 5'b11001, 8'b10000111}, '{16'h0140, 5'b11011, 8'b00001011}};

  pcc_config_header DUT (.clock(clock), .nrst(nrst), .cfg_req(req),
    .cfg_rdata(rdata), .in_d0(d0), .rom_decode_en(rom), .irq_pending(pend),
    .system_error_req(serr), .parity_error_seen(par), .io_decode_en(io),
    .mem_decode_en(mem), .initiator_en(init), .write_invalidate_en(mwi),
    .special_cycle_monitor(scm), .palette_snoop(pal), .back_to_back_en(b2b),
    .addr_data_stepping(step), .parity_react(parr),
    .system_error_out_n(serr_n), .irq_out_n(irq_n), .non_config_en(nc));
  pcc_host_model host (.clock(clock), .cfg_req(req), .cfg_rdata(rdata));

  initial begin
    forever #10 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // Watchdog: a hang counts as a mismatch
  initial begin
    #1000000 error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge clock);
    #1 nrst = 1;
    host.cfg_read(8'h04, 4'h3, q);
    chk(q, 32'h0, "cmd after reset");
    chk(32'({io, mem, init, nc, irq_n, serr_n}), 32'h3, "idle outputs");
    // Table pass: reserved bits always written as zero
    foreach (rows[i]) begin
      {d0, rom, pend, serr, par} = rows[i].ins;
      host.cfg_write(8'h04, 4'h3, {16'h0, rows[i].cmd});
      host.cfg_read(8'h04, 4'h3, q);
      chk(q, {16'h0, rows[i].cmd}, "cmd readback");
      chk(32'({io, mem, init, mwi, parr, serr_n, irq_n, nc}),
          32'(rows[i].exp), "permissions");
    end
    // All ones: fixed and reserved bits must not take
    host.cfg_write(8'h04, 4'hf, 32'hffff_ffff);
    host.cfg_read(8'h04, 4'h3, q);
    chk(q, 32'h0557, "fixed bits");
    chk(32'({scm, pal, b2b, step}), 32'h0, "hardwired outputs");
    host.cfg_write(8'h08, 4'hf, 32'h0);
    host.cfg_read(8'h08, 4'he, q);
    chk(q, 32'h0200_0000, "class code");
    host.cfg_read(8'h34, 4'h1, q);
    chk(q, 32'h50, "chain start");
    host.cfg_read(8'h50, 4'h1, q);
    chk(q, 32'(pcc_pkg::CAP_TYPE_VALUE), "capability type");
    host.cfg_read(8'h3c, 4'hf, q);
    chk(q, 32'h0, "unmapped read");
    // Reset in mid-run, off the clock edge
    @(posedge clock) #1 nrst = 0;
    @(posedge clock) #1 nrst = 1;
    host.cfg_read(8'h04, 4'h3, q);
    chk(q, 32'h0, "cmd after second reset");
    tally_and_finish();
  end
endmodule : pcc_config_header_tb_top
